/* inc/eenvm_pkg.sv */
package eenvm_pkg;
   // register map on the plain software port (word index)
   localparam logic [3:0] ADDR_CTRL = 4'h0; // memory control
   localparam logic [3:0] ADDR_KEY = 4'h1; // unlock key, write only
   localparam logic [3:0] ADDR_NVADR = 4'h2; // memory address
   localparam logic [3:0] ADDR_WDATA = 4'h3; // write latch
   localparam logic [3:0] ADDR_RDATA = 4'h4; // read back data
   localparam logic [3:0] ADDR_VPAGE = 4'h5; // visibility page
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h6; // sticky events
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7; // event mask
   // key values
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // control register fields
   localparam int CTRL_START_BIT = 15; // start bit, upper byte
   localparam int CTRL_ENABLE_BIT = 14; // write enable
   localparam int CTRL_ERR_BIT = 13; // last operation failed
   localparam logic [7:0] CTRL_OP_RESET = 8'h00;
   // operation codes held in the lower byte
   localparam logic [7:0] OP_ERASE_WORD = 8'h58;
   localparam logic [7:0] OP_WRITE_WORD = 8'h04;
   // visibility page values
   localparam logic [7:0] VPAGE_PROGRAM = 8'h00;
   localparam logic [7:0] VPAGE_EEPROM = 8'hFF;
   // address map
   localparam logic [23:0] PROG_TOP = 24'h7FFFFF;
   localparam logic [23:0] EE_BASE_LARGE = 24'h7FFE00;
   localparam int EE_WORDS_LARGE = 256;
   localparam int EE_WORDS_SMALL = 128;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   // operation time
   localparam int OP_TIME_NS = 4000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
   // event bits
   localparam int EV_DONE = 0;
   localparam int EV_ERR = 1;
   // sequencer states
   typedef enum logic [1:0] {
      EE_IDLE = 2'b00,
      EE_BUSY = 2'b01,
      EE_COMMIT = 2'b10
   } eenvm_state_t;
endpackage : eenvm_pkg

/* logic/eenvm_ctrl.sv */
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Function
// - eeprom ends at top program address
// - large configuration holds 256 words
// - small configuration holds 128 words
// - memory is 16-bit individually addressed words
// - read and write in normal operation
// - core never stalls during an operation
// - unlock key register is write only
// - control write accepted one cycle after unlock
// - start bit together with enable bit in unlocked cycle begins operation
// - upper byte holds start and status flag
// - lower byte selects the operation kind
// - fetch address: bit23 zero, bit0 zero
// - window read: bit15 from page bit0
// - visibility page accepts only 00 or FF
module eenvm_ctrl
   import eenvm_pkg::*;
#(
   parameter int WORDS = EE_WORDS_LARGE,
   parameter int OP_CNT = OP_CYCLES,
   parameter bit PAGE_TWO_VALUES = 1'b1
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [21:0] program_counter,
   input wire logic [15:0] effective_addr,
   output logic [23:0] fetch_addr,
   output logic [23:0] window_addr,
   output logic busy,
   output logic irq
);
   localparam int AW = $clog2(WORDS);
   localparam int CW = $clog2(OP_CNT + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(OP_CNT - 1);

   eenvm_state_t state, next_state; // operation sequencer
   logic [1:0] key_stage, next_key_stage; // 0 none, 1 got 55h, 2 open
   logic start, next_start; // start bit
   logic wr_en, next_wr_en; // write enable bit
   logic err, next_err; // failure flag
   logic [7:0] op_sel, next_op_sel; // operation kind
   logic [15:0] nv_addr, next_nv_addr; // word address
   logic [15:0] wlatch, next_wlatch; // data to program
   logic [7:0] vpage, next_vpage; // visibility page
   logic [1:0] irq_stat, next_irq_stat; // sticky events
   logic [1:0] irq_mask, next_irq_mask; // event mask
   logic [CW-1:0] cnt, next_cnt; // operation timer
   logic [15:0] rdata_q, next_rdata_q; // read answer
   logic [23:0] next_fetch_addr, next_window_addr;
   logic next_busy, next_irq;
   logic mem_we; // commit to array
   logic [15:0] mem_wdata;
   logic [15:0] mem_rdata; // registered array read
   logic [1:0] ev; // events this cycle
   logic addr_ok; // address falls inside the array

   // the array sits at the top of program space; low bits index it
   assign addr_ok = (nv_addr[15:AW] == '1);

   eenvm_mem #(
      .WORDS(WORDS),
      .AW(AW)
   ) u_mem (
      .clock(clock),
      .we(mem_we),
      .waddr(nv_addr[AW-1:0]),
      .wdata(mem_wdata),
      .raddr(nv_addr[AW-1:0]),
      .rdata(mem_rdata)
   );

   // next-state logic for control, unlock, timer and events
   always_comb begin
      next_state = state;
      next_key_stage = key_stage;
      next_start = start;
      next_wr_en = wr_en;
      next_err = err;
      next_op_sel = op_sel;
      next_nv_addr = nv_addr;
      next_wlatch = wlatch;
      next_vpage = vpage;
      next_irq_mask = irq_mask;
      next_cnt = cnt;
      mem_we = 1'b0;
      mem_wdata = wlatch;
      ev = 2'b00;
      // the open window lasts one cycle only
      if (key_stage == 2'd2) begin
         next_key_stage = 2'd0;
      end
      if (reg_wr) begin
         // any write other than the expected key breaks the sequence
         if (key_stage == 2'd1 && !(reg_addr == ADDR_KEY)) begin
            next_key_stage = 2'd0;
         end
         case (reg_addr)
            ADDR_KEY: begin
               // key register only advances or clears the unlock stage
               if (reg_wdata[7:0] == KEY_FIRST) begin
                  next_key_stage = 2'd1;
               end else if (reg_wdata[7:0] == KEY_SECOND
                            && key_stage == 2'd1) begin
                  next_key_stage = 2'd2;
               end else begin
                  next_key_stage = 2'd0;
               end
            end
            ADDR_CTRL: begin
               // accepted only in the unlocked cycle and when idle
               if (key_stage == 2'd2 && state == EE_IDLE) begin
                  next_wr_en = reg_wdata[CTRL_ENABLE_BIT];
                  next_op_sel = reg_wdata[7:0];
                  next_err = 1'b0;
                  if (reg_wdata[CTRL_START_BIT]
                      && reg_wdata[CTRL_ENABLE_BIT]) begin
                     next_start = 1'b1;
                     next_state = EE_BUSY;
                     next_cnt = '0;
                  end
               end
            end
            ADDR_NVADR: begin
               if (state == EE_IDLE) begin
                  next_nv_addr = reg_wdata;
               end
            end
            ADDR_WDATA: begin
               if (state == EE_IDLE) begin
                  next_wlatch = reg_wdata;
               end
            end
            ADDR_VPAGE: begin
               // restricted page keeps only the two legal values
               if (!PAGE_TWO_VALUES || reg_wdata[7:0] == VPAGE_PROGRAM
                   || reg_wdata[7:0] == VPAGE_EEPROM) begin
                  next_vpage = reg_wdata[7:0];
               end
            end
            ADDR_IRQ_MASK: begin
               next_irq_mask = reg_wdata[1:0];
            end
            default: begin
               // other addresses hold no writable state here; ADDR_IRQ_STAT is cleared further down
            end
         endcase
      end
      // operation runs in the background; no stall signal to the core
      case (state)
         EE_IDLE: begin
            next_cnt = next_cnt;
         end
         EE_BUSY: begin
            if (cnt == CNT_LAST) begin
               next_state = EE_COMMIT;
            end else begin
               next_cnt = cnt + CW'(1);
            end
         end
         EE_COMMIT: begin
            // program or erase the addressed word, then finish
            if (addr_ok && op_sel == OP_WRITE_WORD) begin
               mem_we = 1'b1;
            end else if (addr_ok && op_sel == OP_ERASE_WORD) begin
               mem_we = 1'b1;
               mem_wdata = ERASED_WORD;
            end else begin
               next_err = 1'b1;
               ev[EV_ERR] = 1'b1;
            end
            next_start = 1'b0;
            next_wr_en = 1'b0;
            next_state = EE_IDLE;
            ev[EV_DONE] = 1'b1;
         end
         default: begin
            next_state = EE_IDLE;
         end
      endcase
      // write-one-to-clear, a new event wins over the clear
      next_irq_stat = irq_stat;
      if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
         next_irq_stat = irq_stat & ~reg_wdata[1:0];
      end
      next_irq_stat = next_irq_stat | ev;
      next_irq = |(next_irq_stat & next_irq_mask);
      next_busy = (next_state != EE_IDLE);
   end

   // read mux; key register reads as zero
   always_comb begin
      next_rdata_q = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CTRL: begin
               next_rdata_q = {start, wr_en, err, 5'h00, op_sel};
            end
            ADDR_KEY: begin
               next_rdata_q = 16'h0000;
            end
            ADDR_NVADR: begin
               next_rdata_q = nv_addr;
            end
            ADDR_WDATA: begin
               next_rdata_q = wlatch;
            end
            ADDR_RDATA: begin
               next_rdata_q = mem_rdata;
            end
            ADDR_VPAGE: begin
               next_rdata_q = {8'h00, vpage};
            end
            ADDR_IRQ_STAT: begin
               next_rdata_q = {14'h0000, irq_stat};
            end
            ADDR_IRQ_MASK: begin
               next_rdata_q = {14'h0000, irq_mask};
            end
            default: begin
               next_rdata_q = 16'h0000;
            end
         endcase
      end
   end

   // program space address formation
   always_comb begin
      next_fetch_addr = {1'b0, program_counter[21:0], 1'b0};
      next_window_addr = {1'b0, vpage, effective_addr[14:0]};
   end

   // state registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= EE_IDLE;
         key_stage <= 2'd0;
         start <= 1'b0;
         wr_en <= 1'b0;
         err <= 1'b0;
         op_sel <= CTRL_OP_RESET;
         nv_addr <= 16'h0000;
         wlatch <= 16'h0000;
         vpage <= VPAGE_PROGRAM;
         irq_stat <= 2'b00;
         irq_mask <= 2'b00;
         cnt <= '0;
         rdata_q <= 16'h0000;
         fetch_addr <= 24'h000000;
         window_addr <= 24'h000000;
         busy <= 1'b0;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         key_stage <= next_key_stage;
         start <= next_start;
         wr_en <= next_wr_en;
         err <= next_err;
         op_sel <= next_op_sel;
         nv_addr <= next_nv_addr;
         wlatch <= next_wlatch;
         vpage <= next_vpage;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         cnt <= next_cnt;
         rdata_q <= next_rdata_q;
         fetch_addr <= next_fetch_addr;
         window_addr <= next_window_addr;
         busy <= next_busy;
         irq <= next_irq;
      end
   end

   assign reg_rdata = rdata_q;
endmodule : eenvm_ctrl

/* logic/eenvm_mem.sv */
`timescale 1ns/1ps
// word memory with registered read data
module eenvm_mem #(
   parameter int WORDS = 256,
   parameter int AW = 8
) (
   input wire logic clock,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [15:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [15:0] rdata
);
   logic [15:0] store [WORDS]; // cell array
   // write port and registered read port
   always_ff @(posedge clock) begin
      if (we) begin
         store[waddr] <= wdata;
      end
      rdata <= store[raddr];
   end
endmodule : eenvm_mem

/* tb/eenvm_core_model.sv */
`timescale 1ns/1ps
// processor core side: register port master and address source
module eenvm_core_model
   import eenvm_pkg::*;
(
   input wire logic clock,
   output logic [3:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [21:0] program_counter,
   output logic [15:0] effective_addr
);
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {program_counter, effective_addr} = '0;
   end
   // one bus cycle, strobe held until idle or the next cycle
   task automatic cyc(input logic w, input logic [3:0] a,
      input logic [15:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
   endtask : cyc
   // release both strobes for one cycle
   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clock);
   endtask : idle
   // keys and start back to back, nothing may slip between
   task automatic start_op(input logic [7:0] op);
      cyc(1'b1, ADDR_KEY, {8'h00, KEY_FIRST});
      cyc(1'b1, ADDR_KEY, {8'h00, KEY_SECOND});
      cyc(1'b1, ADDR_CTRL, {8'hC0, op});
      idle();
   endtask : start_op
endmodule : eenvm_core_model

/* tb/eenvm_monitor.sv */
`timescale 1ns/1ps
// port checker for the control block
module eenvm_monitor
   import eenvm_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [21:0] program_counter,
   input wire logic [15:0] effective_addr,
   input wire logic [23:0] fetch_addr,
   input wire logic [23:0] window_addr,
   input wire logic busy,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire key_lo = reg_wr && reg_addr == ADDR_KEY && reg_wdata[7:0] == 8'h55;
   wire key_hi = reg_wr && reg_addr == ADDR_KEY && reg_wdata[7:0] == 8'hAA;
   wire ctrl_go = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[15];
   // full unlock ending in a start request while idle
   sequence unlock_go;
      key_lo ##1 key_hi ##1 (ctrl_go && !busy);
   endsequence
   fetch_form_a: assert property (!$past(sys_rst) |->
      fetch_addr == {1'b0, $past(program_counter), 1'b0})
      else $error("fetch address wrong");
   window_form_a: assert property (!$past(sys_rst) |->
      !window_addr[23] && window_addr[14:0] == $past(effective_addr[14:0]))
      else $error("window address wrong");
   unlock_start_a: assert property (unlock_go |=> busy)
      else $error("unlocked start ignored");
   start_cause_a: assert property ($rose(busy) |-> $past(ctrl_go)
      && $past(key_hi, 2) && $past(key_lo, 3))
      else $error("start without unlock");
   busy_bound_a: assert property ($rose(busy) |->
      busy [*4] ##[1:8] !busy)
      else $error("operation length wrong");
   key_read_a: assert property (reg_rd && reg_addr == ADDR_KEY |=>
      reg_rdata == 16'h0000)
      else $error("key readable");
   idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read");
   ctrl_idle_a: assert property (reg_rd && reg_addr == ADDR_CTRL
      && !busy |=> !reg_rdata[CTRL_START_BIT])
      else $error("start bit left set");
endmodule : eenvm_monitor
bind eenvm_ctrl eenvm_monitor mon (.clock(clock), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .irq(irq),
   .program_counter(program_counter), .effective_addr(effective_addr),
   .fetch_addr(fetch_addr), .window_addr(window_addr));

/* tb/test_data_eeprom_nvm_control.sv */
`timescale 1ns/1ps
module test_data_eeprom_nvm_control
   import eenvm_pkg::*;
   ;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, busy, irq, rd_seen = 1'b0;
   logic [21:0] pc;
   logic [15:0] ea;
   logic [23:0] fetch_addr, window_addr;
   logic [15:0] exp_q[$]; // expected read data, oldest first
   int num_errors = 0;
   int checks = 0;
   always #2 clock = ~clock;
   eenvm_core_model core (.clock(clock), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .program_counter(pc), .effective_addr(ea));
   eenvm_ctrl #(.OP_CNT(4)) uut (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .program_counter(pc),
      .effective_addr(ea), .fetch_addr(fetch_addr),
      .window_addr(window_addr), .busy(busy), .irq(irq));
   task automatic chk(input logic [23:0] e, input logic [23:0] a);
      checks++;
      if (a !== e) begin
         num_errors++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask : chk
   // read: note the expectation, the watcher compares it
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      core.cyc(1'b0, a, 16'h0000);
      core.idle();
   endtask : rd
   // watcher: read data stand in the cycle after the strobe
   always @(negedge clock) begin
      if (rd_seen) begin
         chk(exp_q.pop_front(), reg_rdata);
      end
      rd_seen = reg_rd;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   // bounded wait for the operation to end
   task automatic wait_idle();
      int n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(negedge clock);
         n++;
      end
      if (n == 50) begin
         num_errors++;
         end_sim();
      end
      @(posedge clock);
   endtask : wait_idle
   initial begin
      logic [15:0] wd;
      logic [7:0] ops[3] = '{OP_WRITE_WORD, OP_ERASE_WORD, 8'h11};
      logic [3:0] zr[4] = '{ADDR_CTRL, ADDR_KEY, ADDR_IRQ_STAT, 4'hF};
      wd = 16'($urandom(32'hD2FCACE1));
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      foreach (zr[i]) rd(zr[i], 16'h0000);
      $display("reset test done");
      pc <= 22'($urandom);
      ea <= 16'($urandom) | 16'h8000;
      core.cyc(1'b1, ADDR_VPAGE, 16'h003C);
      rd(ADDR_VPAGE, 16'h0000);
      core.cyc(1'b1, ADDR_VPAGE, {8'h00, VPAGE_EEPROM});
      rd(ADDR_VPAGE, 16'h00FF);
      @(negedge clock);
      chk({1'b0, pc, 1'b0}, fetch_addr);
      chk({1'b0, VPAGE_EEPROM, ea[14:0]}, window_addr);
      @(posedge clock);
      $display("address test done");
      core.cyc(1'b1, ADDR_KEY, 16'h0055);
      core.cyc(1'b1, ADDR_NVADR, 16'hFF05);
      core.cyc(1'b1, ADDR_KEY, 16'h00AA);
      core.cyc(1'b1, ADDR_CTRL, 16'hC004);
      core.cyc(1'b1, ADDR_KEY, 16'h0055);
      core.cyc(1'b1, ADDR_CTRL, 16'hC004);
      rd(ADDR_CTRL, 16'h0000);
      $display("broken unlock test done");
      foreach (ops[i]) begin
         wd = 16'($urandom);
         core.cyc(1'b1, ADDR_WDATA, wd);
         core.cyc(1'b1, ADDR_IRQ_MASK, 16'h0003);
         core.cyc(1'b1, ADDR_IRQ_STAT, 16'h0003);
         core.idle();
         core.start_op(ops[i]);
         rd(ADDR_CTRL, {8'hC0, ops[i]});
         wait_idle();
         rd(ADDR_IRQ_STAT, i == 2 ? 16'h0003 : 16'h0001);
         rd(ADDR_CTRL, {2'b00, i == 2, 5'h00, ops[i]});
         rd(ADDR_RDATA, i == 0 ? wd : ERASED_WORD);
         chk(24'h000001, {23'h000000, irq});
         $display("operation test %0d done", i);
      end
      core.cyc(1'b1, ADDR_IRQ_MASK, 16'h0000);
      core.idle();
      chk(24'h000000, {23'h000000, irq});
      core.cyc(1'b1, ADDR_IRQ_MASK, 16'h0003);
      core.cyc(1'b1, ADDR_IRQ_STAT, 16'h0003);
      rd(ADDR_IRQ_STAT, 16'h0000);
      chk(24'h000000, {23'h000000, irq});
      $display("interrupt test done");
      end_sim();
   end
endmodule : test_data_eeprom_nvm_control
